// [hdl/scrp_defs.vh]
// register offsets, field positions, reset values and frame timing for the serial register port
`ifndef SCRP_DEFS_VH
`define SCRP_DEFS_VH

`define SCRP_FRAME_BITS 6'd32
`define SCRP_START_PAT 4'hc
`define SCRP_OP_DEV_WR 2'h0
`define SCRP_OP_ALL_WR 2'h1
`define SCRP_OP_DEV_RD 2'h2
`define SCRP_OP_ALL_RD 2'h3
// bit counts after the start pattern (count of bits already taken)
`define SCRP_CNT_OP_DONE 6'd6
`define SCRP_CNT_ID_DONE 6'd14
`define SCRP_CNT_ADR_DONE 6'd22
`define SCRP_CNT_GAP_DONE 6'd23
`define SCRP_CNT_DATA_DONE 6'd31

`define SCRP_ADR_IDENTITY 8'h00
`define SCRP_ADR_CONFIG 8'h01
`define SCRP_ADR_POWER 8'h02
`define SCRP_ADR_WRITE_DATA_SERIAL_LOAD 8'h03
`define SCRP_ADR_REFRESH_BANK_SELECT 8'h04
`define SCRP_ADR_REFRESH_ROW_HIGH 8'h05
`define SCRP_ADR_REFRESH_ROW_MIDDLE 8'h06
`define SCRP_ADR_REFRESH_ROW_LOW 8'h07
`define SCRP_ADR_CCE 8'h08
`define SCRP_ADR_CCO 8'h09
`define SCRP_ADR_ZCE 8'h0a
`define SCRP_ADR_ZCO 8'h0b
`define SCRP_ADR_DELAY 8'h0c

`define SCRP_CFG_LOAD_EN_BIT 7
`define SCRP_PM_EXIT_BIT 0
`define SCRP_PM_STATE_BIT 1
`define SCRP_IDENTITY_MASK 8'h3f
`define SCRP_CFG_MASK 8'h83
`define SCRP_REFRESH_BANK_SELECT_MASK 8'h37
`define SCRP_RST_VALUE 8'h00
`define SCRP_RST_DELAY 8'h00

`endif

// [hdl/scrp_port.v]
// serial control register port: frame decode, register access, chained read output
// Notes on behaviour
// - a frame starts with pattern 1100; next 28 bits form the transaction
// - two-bit op field follows; 10 is single-device read
// - one zero gap bit; register accessed and output driver enabled
// - eight zero command bits while selected device shifts eight data bits out
// - data msb first, launched after edge 23, sampled at edge 24
// - forced read ignores identity; every device answers
// - unmatched device read forwards chain input to output edges 23 to 31
// - op 00 unicast write, 01 broadcast write, 10 unicast read, 11 all read
// - registers up to eight bits, selected by address, defined reset state
// - stored identity compared to frame identity to select device
// - config holds pin-pair width field and serial load enable
// - power exit bit leaves powerdown; powerdown clears it; status shows state
// - serial load register writes data into memory
// - refresh bank field and multi-bank count drive refresh
// - three refresh row registers hold the refresh row address
// - current calibration values for even and odd data pins
// - termination calibration values for even and odd data pins
// - frame spans 32 serial edges; serial clock may stop when idle
// - command and data sampled and driven around serial clock falling edge
`timescale 1ns/1ps
`include "scrp_defs.vh"
module scrp_port (
   // system
   input wire clk,
   input wire sys_rst,
   // serial pins
   input wire serial_clock,
   input wire serial_op_line,
   input wire chain_serial_input,
   output reg chain_serial_output,
   output reg chain_serial_output_oe,
   // memory side events
   input wire powerdown_command,
   output reg write_data_serial_load_load_pulse,
   output reg [7:0] write_data_serial_load_data,
   // register contents toward the core
   output reg [5:0] device_identity_field,
   output reg [7:0] configuration,
   output reg power_state_status,
   output reg [7:0] refresh_bank_select,
   output reg [23:0] refresh_row,
   output reg [7:0] even_pin_current_value,
   output reg [7:0] odd_pin_current_value,
   output reg [7:0] even_pin_termination_value,
   output reg [7:0] odd_pin_termination_value,
   output reg [7:0] latency_delay_control
);
   localparam ST_HUNT = 2'd0;
   localparam ST_BODY = 2'd1;
   localparam ST_READ = 2'd2;
   localparam ST_FWD = 2'd3;

   wire [2:0] pins_s;
   reg sck_d_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [3:0] hunt_r;
   reg [5:0] cnt_r;
   reg [1:0] op_r;
   reg [7:0] id_r;
   reg [7:0] adr_r;
   reg [7:0] shift_r;
   reg sel_r;
   reg wr_en;
   reg [7:0] wr_data;
   wire [7:0] rd_data;
   wire fall;
   wire sck_s;
   wire cmd_s;
   wire sdi_s;
   wire write_data_serial_load_load;
   wire [5:0] id_w;
   wire [7:0] cfg_w;
   wire pst_w;
   wire [7:0] write_data_serial_load_w;
   wire [7:0] refresh_bank_select_w;
   wire [23:0] row_w;
   wire [7:0] cce_w;
   wire [7:0] cco_w;
   wire [7:0] zce_w;
   wire [7:0] zco_w;
   wire [7:0] dly_w;

   ////////////////////////////////////////////////////////////////////////////
   scrp_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({serial_clock, serial_op_line, chain_serial_input}),
      .dout(pins_s)
   );
   assign sck_s = pins_s[2];
   assign cmd_s = pins_s[1];
   assign sdi_s = pins_s[0];
   // all pins share the same sync delay so sampling stays aligned
   assign fall = sck_d_r && !sck_s;

   // selection test used at the gap bit
   function selected;
      input [1:0] op;
      input [5:0] fid;
      input [5:0] mine;
      selected = op[0] ? 1'b1 : (fid == mine);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      state_nxt = state_r;
      wr_en = 1'b0;
      wr_data = shift_r;
      case (state_r)
         ST_HUNT: begin
            if (fall && {hunt_r[2:0], cmd_s} == `SCRP_START_PAT) begin
               state_nxt = ST_BODY;
            end
         end
         ST_BODY: begin
            if (fall && cnt_r == `SCRP_CNT_ADR_DONE) begin
               if (!op_r[1]) begin
                  state_nxt = ST_BODY; // writes keep collecting data
               end else if (selected(op_r, id_r[5:0], id_w)) begin
                  state_nxt = ST_READ;
               end else begin
                  state_nxt = ST_FWD;
               end
            end else if (fall && cnt_r == `SCRP_CNT_DATA_DONE) begin
               // last data bit was taken at the previous fall
               wr_en = sel_r;
               state_nxt = ST_HUNT;
            end
         end
         ST_READ: begin
            if (fall && cnt_r == `SCRP_CNT_DATA_DONE) begin
               state_nxt = ST_HUNT;
            end
         end
         ST_FWD: begin
            if (fall && cnt_r == `SCRP_CNT_DATA_DONE) begin
               state_nxt = ST_HUNT;
            end
         end
         default: state_nxt = ST_HUNT;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (sys_rst) begin
         sck_d_r <= 1'b0;
         state_r <= ST_HUNT;
         hunt_r <= 4'h0;
         cnt_r <= 6'h00;
         op_r <= 2'h0;
         id_r <= 8'h00;
         adr_r <= 8'h00;
         shift_r <= 8'h00;
         sel_r <= 1'b0;
         chain_serial_output <= 1'b0;
         chain_serial_output_oe <= 1'b0;
      end else begin
         sck_d_r <= sck_s;
         state_r <= state_nxt;
         if (fall) begin
            case (state_r)
               ST_HUNT: begin
                  hunt_r <= {hunt_r[2:0], cmd_s};
                  cnt_r <= 6'd4;
                  chain_serial_output_oe <= 1'b0;
               end
               default: begin
                  hunt_r <= 4'h0;
                  cnt_r <= cnt_r + 6'd1;
                  shift_r <= {shift_r[6:0], cmd_s};
                  if (cnt_r == `SCRP_CNT_OP_DONE - 6'd1) begin
                     op_r <= {shift_r[0], cmd_s};
                  end
                  if (cnt_r == `SCRP_CNT_ID_DONE - 6'd1) begin
                     id_r <= {shift_r[6:0], cmd_s};
                  end
                  if (cnt_r == `SCRP_CNT_ADR_DONE - 6'd1) begin
                     adr_r <= {shift_r[6:0], cmd_s};
                  end
                  if (cnt_r == `SCRP_CNT_ADR_DONE) begin
                     sel_r <= selected(op_r, id_r[5:0], id_w);
                     if (op_r[1]) begin
                        // access during gap bit; msb must stand before the next fall
                        chain_serial_output_oe <= 1'b1;
                        if (selected(op_r, id_r[5:0], id_w)) begin
                           shift_r <= {rd_data[6:0], 1'b0};
                           chain_serial_output <= rd_data[7];
                        end else begin
                           chain_serial_output <= sdi_s;
                        end
                     end
                  end
                  if (state_r == ST_READ) begin
                     // remaining bits one per fall; zero fill after bit 0
                     chain_serial_output <= shift_r[7];
                     shift_r <= {shift_r[6:0], 1'b0};
                  end
                  if (state_r == ST_FWD) begin
                     chain_serial_output <= sdi_s;
                  end
                  if ((state_r == ST_READ || state_r == ST_FWD) &&
                      cnt_r == `SCRP_CNT_DATA_DONE) begin
                     chain_serial_output_oe <= 1'b0;
                     chain_serial_output <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   scrp_regfile u_regs (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(wr_en),
      .addr(adr_r),
      .wdata(wr_data),
      .rdata(rd_data),
      .powerdown_command(powerdown_command),
      .write_data_serial_load_load(write_data_serial_load_load),
      .device_identity_field(id_w),
      .configuration(cfg_w),
      .power_state_status(pst_w),
      .write_data_serial_load(write_data_serial_load_w),
      .refresh_bank_select(refresh_bank_select_w),
      .refresh_row(row_w),
      .even_pin_current_value(cce_w),
      .odd_pin_current_value(cco_w),
      .even_pin_termination_value(zce_w),
      .odd_pin_termination_value(zco_w),
      .latency_delay_control(dly_w)
   );

   // outputs registered to keep top ports flop-driven
   always @(posedge clk) begin
      if (sys_rst) begin
         write_data_serial_load_load_pulse <= 1'b0;
         write_data_serial_load_data <= 8'h00;
         device_identity_field <= 6'h00;
         configuration <= 8'h00;
         power_state_status <= 1'b0;
         refresh_bank_select <= 8'h00;
         refresh_row <= 24'h000000;
         even_pin_current_value <= 8'h00;
         odd_pin_current_value <= 8'h00;
         even_pin_termination_value <= 8'h00;
         odd_pin_termination_value <= 8'h00;
         latency_delay_control <= `SCRP_RST_DELAY;
      end else begin
         write_data_serial_load_load_pulse <= write_data_serial_load_load;
         if (write_data_serial_load_load) begin
            write_data_serial_load_data <= wr_data;
         end
         device_identity_field <= id_w;
         configuration <= cfg_w;
         power_state_status <= pst_w;
         refresh_bank_select <= refresh_bank_select_w;
         refresh_row <= row_w;
         even_pin_current_value <= cce_w;
         odd_pin_current_value <= cco_w;
         even_pin_termination_value <= zce_w;
         odd_pin_termination_value <= zco_w;
         latency_delay_control <= dly_w;
      end
   end
endmodule // scrp_port

// [hdl/scrp_regfile.v]
// control register storage with access rules per register
`timescale 1ns/1ps
`include "scrp_defs.vh"
module scrp_regfile (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // access
   input wire wr_en,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata,
   // side events
   input wire powerdown_command,
   output wire write_data_serial_load_load,
   // register contents
   output wire [5:0] device_identity_field,
   output wire [7:0] configuration,
   output wire power_state_status,
   output wire [7:0] write_data_serial_load,
   output wire [7:0] refresh_bank_select,
   output wire [23:0] refresh_row,
   output wire [7:0] even_pin_current_value,
   output wire [7:0] odd_pin_current_value,
   output wire [7:0] even_pin_termination_value,
   output wire [7:0] odd_pin_termination_value,
   output wire [7:0] latency_delay_control
);
   // identity, cfg, write_data_serial_load, refresh_bank_select, refresh_row_high, refresh_row_middle, refresh_row_low, cce, cco, zce, zco, delay
   reg [7:0] regs_r [0:11];
   reg power_exit_bit_r;
   reg power_state_r;
   integer i;

   function [3:0] slot;
      input [7:0] a;
      case (a)
         `SCRP_ADR_IDENTITY: slot = 4'h0;
         `SCRP_ADR_CONFIG: slot = 4'h1;
         `SCRP_ADR_WRITE_DATA_SERIAL_LOAD: slot = 4'h2;
         `SCRP_ADR_REFRESH_BANK_SELECT: slot = 4'h3;
         `SCRP_ADR_REFRESH_ROW_HIGH: slot = 4'h4;
         `SCRP_ADR_REFRESH_ROW_MIDDLE: slot = 4'h5;
         `SCRP_ADR_REFRESH_ROW_LOW: slot = 4'h6;
         `SCRP_ADR_CCE: slot = 4'h7;
         `SCRP_ADR_CCO: slot = 4'h8;
         `SCRP_ADR_ZCE: slot = 4'h9;
         `SCRP_ADR_ZCO: slot = 4'ha;
         `SCRP_ADR_DELAY: slot = 4'hb;
         default: slot = 4'hf;
      endcase
   endfunction

   function [7:0] wmask;
      input [3:0] s;
      case (s)
         4'h0: wmask = `SCRP_IDENTITY_MASK;
         4'h1: wmask = `SCRP_CFG_MASK;
         4'h3: wmask = `SCRP_REFRESH_BANK_SELECT_MASK;
         default: wmask = 8'hff;
      endcase
   endfunction

   always @(posedge clk) begin
      if (sys_rst) begin
         for (i = 0; i < 12; i = i + 1) begin
            regs_r[i] <= `SCRP_RST_VALUE;
         end
         power_exit_bit_r <= 1'b0;
         power_state_r <= 1'b0;
      end else begin
         if (wr_en && slot(addr) != 4'hf) begin
            regs_r[slot(addr)] <= wdata & wmask(slot(addr));
         end
         // exit request wins over a coincident powerdown clear
         if (wr_en && addr == `SCRP_ADR_POWER && wdata[`SCRP_PM_EXIT_BIT]) begin
            power_exit_bit_r <= 1'b1;
            power_state_r <= 1'b1;
         end else if (powerdown_command) begin
            power_exit_bit_r <= 1'b0;
            power_state_r <= 1'b0;
         end
      end
   end

   always @* begin
      rdata = 8'h00;
      case (addr)
         `SCRP_ADR_POWER: rdata = {6'h00, power_state_r, power_exit_bit_r};
         `SCRP_ADR_WRITE_DATA_SERIAL_LOAD: rdata = 8'h00; // write-only
         default: begin
            if (slot(addr) != 4'hf) begin
               rdata = regs_r[slot(addr)];
            end
         end
      endcase
   end

   // load to memory only when enabled in config
   assign write_data_serial_load_load = wr_en && addr == `SCRP_ADR_WRITE_DATA_SERIAL_LOAD && regs_r[1][`SCRP_CFG_LOAD_EN_BIT];
   assign device_identity_field = regs_r[0][5:0];
   assign configuration = regs_r[1];
   assign power_state_status = power_state_r;
   assign write_data_serial_load = regs_r[2];
   assign refresh_bank_select = regs_r[3];
   assign refresh_row = {regs_r[4], regs_r[5], regs_r[6]};
   assign even_pin_current_value = regs_r[7];
   assign odd_pin_current_value = regs_r[8];
   assign even_pin_termination_value = regs_r[9];
   assign odd_pin_termination_value = regs_r[10];
   assign latency_delay_control = regs_r[11];
endmodule // scrp_regfile

// [hdl/scrp_sync.v]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scrp_sync #(
   parameter WIDTH = 3
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // data
   input wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;
   always @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end
   assign dout = sync_r;
endmodule // scrp_sync

// [tb/scrp_ctrl_model.sv]
// memory controller model driving serial frames, plus an upstream chain device
`timescale 1ns/1ps
module scrp_ctrl_model (
   // system
   input wire clk,
   // serial pins
   output reg serial_clock = 1'b1,
   output reg serial_op_line = 1'b0,
   output reg chain_serial_input = 1'b0,
   input wire chain_serial_output,
   input wire chain_serial_output_oe
);
   reg [7:0] rd_byte = 8'h00;
   reg oe_all = 1'b0;
   ////////////////////////////////////////////////////////////////
   // one 32-bit frame, 4 clk per half period; clock stands high between frames
   task frame(input [1:0] op, input [5:0] fid, input [7:0] adr, input [7:0] wd,
              input [7:0] up);
      reg [31:0] bits;
      integer i;
      begin
         bits = {4'hc, op, 2'b00, fid, adr, 1'b0, wd, 1'b0};
         oe_all = 1'b1;
         for (i = 31; i >= 0; i = i - 1) begin
            @(posedge clk);
            serial_clock <= 1'b1;
            serial_op_line <= bits[i];
            repeat (4) @(posedge clk);
            serial_clock <= 1'b0;
            if (i >= 1 && i <= 8) begin
               rd_byte[i-1] <= chain_serial_output;
               oe_all <= oe_all & chain_serial_output_oe;
            end
            // upstream launches each bit one period ahead, otherwise a changing pattern
            if (i >= 2 && i <= 9)
               chain_serial_input <= up[i-2];
            else
               chain_serial_input <= ~chain_serial_input;
            repeat (3) @(posedge clk);
         end
         @(posedge clk);
         serial_clock <= 1'b1;
         serial_op_line <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
endmodule // scrp_ctrl_model

// [tb/scrp_port_bench.sv]
// self-checking bench for the serial register port
`timescale 1ns/1ps
module scrp_port_bench;
   reg clk;
   reg sys_rst;
   reg powerdown_command;
   reg [7:0] load_cnt = 8'h00;
   wire serial_clock, serial_op_line, chain_serial_input;
   wire chain_serial_output, chain_serial_output_oe, write_data_serial_load_load_pulse, power_state_status;
   wire [7:0] write_data_serial_load_data, configuration, refresh_bank_select, latency_delay_control;
   wire [7:0] even_pin_current_value, odd_pin_current_value;
   wire [7:0] even_pin_termination_value, odd_pin_termination_value;
   wire [5:0] device_identity_field;
   wire [23:0] refresh_row;
   integer num_errors, total_checks;
   integer k;
   scrp_ctrl_model ctl (.clk(clk), .serial_clock(serial_clock), .serial_op_line(serial_op_line),
      .chain_serial_input(chain_serial_input), .chain_serial_output(chain_serial_output),
      .chain_serial_output_oe(chain_serial_output_oe));
   scrp_port dut (.clk(clk), .sys_rst(sys_rst), .serial_clock(serial_clock),
      .serial_op_line(serial_op_line), .chain_serial_input(chain_serial_input),
      .chain_serial_output(chain_serial_output), .chain_serial_output_oe(chain_serial_output_oe),
      .powerdown_command(powerdown_command), .write_data_serial_load_load_pulse(write_data_serial_load_load_pulse),
      .write_data_serial_load_data(write_data_serial_load_data), .device_identity_field(device_identity_field),
      .configuration(configuration), .power_state_status(power_state_status),
      .refresh_bank_select(refresh_bank_select), .refresh_row(refresh_row),
      .even_pin_current_value(even_pin_current_value),
      .odd_pin_current_value(odd_pin_current_value),
      .even_pin_termination_value(even_pin_termination_value),
      .odd_pin_termination_value(odd_pin_termination_value),
      .latency_delay_control(latency_delay_control));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (write_data_serial_load_load_pulse === 1'b1) load_cnt <= load_cnt + 8'h01;
   ////////////////////////////////////////////////////////////////
   task check8(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd(input [1:0] op, input [5:0] fid, input [7:0] adr, input [7:0] up, input [7:0] exp);
      begin
         ctl.frame(op, fid, adr, 8'h00, up);
         check8(ctl.rd_byte, exp);
         check8({7'h00, ctl.oe_all}, 8'h01);
      end
   endtask
   task wr(input [1:0] op, input [5:0] fid, input [7:0] adr, input [7:0] wd);
      ctl.frame(op, fid, adr, wd, 8'h00);
   endtask
   function [7:0] port_of(input [7:0] a);
      case (a)
         8'h04: port_of = refresh_bank_select;
         8'h05: port_of = refresh_row[23:16];
         8'h06: port_of = refresh_row[15:8];
         8'h07: port_of = refresh_row[7:0];
         8'h08: port_of = even_pin_current_value;
         8'h09: port_of = odd_pin_current_value;
         8'h0a: port_of = even_pin_termination_value;
         8'h0b: port_of = odd_pin_termination_value;
         default: port_of = latency_delay_control;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////
   task t_reset;
      for (k = 0; k < 13; k = k + 1)
         rd(2'h3, 6'h2a, k[7:0], 8'h00, 8'h00);
   endtask
   task t_identity;
      begin
         wr(2'h0, 6'h00, 8'h00, 8'hff);
         check8({2'b00, device_identity_field}, 8'h3f);
         wr(2'h0, 6'h3f, 8'h00, 8'h25);
         check8({2'b00, device_identity_field}, 8'h25);
      end
   endtask
   task t_select;
      begin
         wr(2'h0, 6'h11, 8'h08, 8'haa);
         check8(even_pin_current_value, 8'h00);
         rd(2'h2, 6'h11, 8'h08, 8'h96, 8'h96);
         rd(2'h2, 6'h11, 8'h08, 8'h69, 8'h69);
      end
   endtask
   task t_table;
      reg [7:0] v;
      for (k = 4; k < 13; k = k + 1) begin
         v = {k[3:0], ~k[3:0]};
         wr(2'h1, 6'h3e, k[7:0], v);
         if (k == 4) v = v & 8'h37;
         check8(port_of(k[7:0]), v);
         rd(2'h2, 6'h25, k[7:0], 8'h5c, v);
      end
   endtask
   task t_power;
      begin
         wr(2'h0, 6'h25, 8'h02, 8'h01);
         check8({7'h00, power_state_status}, 8'h01);
         rd(2'h2, 6'h25, 8'h02, 8'h00, 8'h03);
         powerdown_command <= 1'b1;
         @(posedge clk);
         powerdown_command <= 1'b0;
         repeat (4) @(posedge clk);
         check8({7'h00, power_state_status}, 8'h00);
         rd(2'h2, 6'h25, 8'h02, 8'h00, 8'h00);
      end
   endtask
   task t_load;
      reg [7:0] n;
      begin
         wr(2'h0, 6'h25, 8'h01, 8'hff);
         check8(configuration, 8'h83);
         n = load_cnt;
         wr(2'h0, 6'h25, 8'h03, 8'h5a);
         check8({load_cnt == n + 8'h01, write_data_serial_load_data[6:0]}, 8'hda);
         rd(2'h2, 6'h25, 8'h03, 8'h00, 8'h00);
         rd(2'h2, 6'h25, 8'h40, 8'h00, 8'h00);
         wr(2'h0, 6'h25, 8'h01, 8'h00);
         n = load_cnt;
         wr(2'h0, 6'h25, 8'h03, 8'ha5);
         check8({load_cnt != n, write_data_serial_load_data[6:0]}, 8'h5a);
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      num_errors = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      powerdown_command = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset;
      t_identity;
      t_select;
      t_table;
      t_power;
      t_load;
      results;
   end
   // run needs about 12000 clk; cut off well beyond that
   initial begin
      #400000;
      num_errors = num_errors + 1;
      results;
   end
endmodule // scrp_port_bench

// [tb/scrp_port_properties.sv]
// timing and value checks on the serial register port pins
`timescale 1ns/1ps
module scrp_port_properties (
   // system
   input wire clk,
   input wire sys_rst,
   // serial pins
   input wire serial_clock,
   input wire chain_serial_output_oe,
   // core side
   input wire powerdown_command,
   input wire write_data_serial_load_load_pulse,
   // register copies
   input wire [5:0] device_identity_field,
   input wire [7:0] configuration,
   input wire power_state_status,
   input wire [7:0] refresh_bank_select
);
   reg [4:0] idle_cnt_r;
   // counts clk cycles with the serial clock standing high
   always @(posedge clk) begin
      if (sys_rst || !serial_clock)
         idle_cnt_r <= 5'h00;
      else if (idle_cnt_r != 5'h1f)
         idle_cnt_r <= idle_cnt_r + 5'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////
   reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
      !chain_serial_output_oe && configuration == 8'h00 && device_identity_field == 6'h00)
      else $error("outputs not cleared by reset");
   oe_idle_off_a: assert property (idle_cnt_r >= 5'd12 |-> !chain_serial_output_oe)
      else $error("output driver on while serial clock idle");
   oe_hold_a: assert property ($rose(chain_serial_output_oe)
      |=> chain_serial_output_oe [*8])
      else $error("output driver dropped inside read window");
   oe_span_a: assert property ($rose(chain_serial_output_oe)
      |-> ##[71:73] $fell(chain_serial_output_oe))
      else $error("read window length wrong");
   load_pulse_a: assert property (write_data_serial_load_load_pulse |=> !write_data_serial_load_load_pulse)
      else $error("serial load pulse longer than one cycle");
   load_enable_a: assert property (write_data_serial_load_load_pulse |-> configuration[7])
      else $error("serial load without load enable");
   config_mask_a: assert property (configuration[6:2] == 5'h00)
      else $error("reserved configuration bits set");
   bank_mask_a: assert property (
      refresh_bank_select[7:6] == 2'h0 && !refresh_bank_select[3])
      else $error("reserved refresh bank bits set");
   power_clear_a: assert property (
      powerdown_command && serial_clock && idle_cnt_r >= 5'd8 |-> ##[1:3] !power_state_status)
      else $error("powerdown did not clear power state");
   read_cov_c: cover property ($rose(chain_serial_output_oe));
   load_cov_c: cover property (write_data_serial_load_load_pulse);
   power_cov_c: cover property ($fell(power_state_status));
endmodule // scrp_port_properties

bind scrp_port scrp_port_properties chk (
   .clk(clk),
   .sys_rst(sys_rst),
   .serial_clock(serial_clock),
   .chain_serial_output_oe(chain_serial_output_oe),
   .powerdown_command(powerdown_command),
   .write_data_serial_load_load_pulse(write_data_serial_load_load_pulse),
   .device_identity_field(device_identity_field),
   .configuration(configuration),
   .power_state_status(power_state_status),
   .refresh_bank_select(refresh_bank_select)
);
